// ==== hw/afe_spi_slave.sv ====
// Purpose: Serial control port slave of the analog front-end
// Assumes: Host is serial master, mode with input on rise, output on fall
// Notes: Register file lives in the serial clock domain; reset crosses in
//
// How it works
// - One 16-bit frame, MSB first
// - Shift only while select low
// - Output changes on each falling clock edge
// - Input sampled on each rising clock edge
// - Write commits after sixteenth rising edge
// - Read data driven from ninth falling edge
`timescale 1ns/10ps
module afe_spi_slave (
  // System clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  // Serial link
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_SDI,
  output logic O_SDO,
  output logic O_SDO_OE,
  // Committed writes, system domain
  output logic O_WR_STROBE,
  output logic [afe_spi_pkg::ADDR_W-1:0] O_WR_ADDR,
  output logic [afe_spi_pkg::DATA_W-1:0] O_WR_DATA
);
  // ********************************
  // Reset into the link domain
  // ********************************
  // Host pulses the system reset before any frame
  logic link_rst;
  afe_spi_sync u_rst_sync (
    .clk(I_SCLK),
    .srst(1'b0),
    .ce(1'b1),
    .i_async(I_SRST),
    .o_sync(link_rst)
  );

  // ********************************
  // Receive side, rising edge
  // ********************************
  logic [afe_spi_pkg::CNT_W-1:0] cnt_q;
  logic [afe_spi_pkg::CNT_W-1:0] cnt_d;
  logic [afe_spi_pkg::FRAME_BITS-1:0] shift_q;
  logic [afe_spi_pkg::FRAME_BITS-1:0] shift_d;
  logic [afe_spi_pkg::DATA_W-1:0] regs_q [afe_spi_pkg::NUM_REGS];
  logic [afe_spi_pkg::DATA_W-1:0] regs_d [afe_spi_pkg::NUM_REGS];
  logic wr_tgl_q;
  logic wr_tgl_d;
  logic [afe_spi_pkg::ADDR_W-1:0] wr_addr_q;
  logic [afe_spi_pkg::ADDR_W-1:0] wr_addr_d;
  logic [afe_spi_pkg::DATA_W-1:0] wr_data_q;
  logic [afe_spi_pkg::DATA_W-1:0] wr_data_d;
  logic [afe_spi_pkg::FRAME_BITS-1:0] frame;
  logic clr_q;

  function automatic logic [afe_spi_pkg::ADDR_W-1:0] addr_of(input logic [afe_spi_pkg::FRAME_BITS-1:0] f);
    addr_of = f[afe_spi_pkg::ADDR_MSB:afe_spi_pkg::ADDR_LSB];
  endfunction

  // Select rise clears the counter, seen at next rising edge
  always_ff @(posedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      clr_q <= 1'b1;
    end else begin
      clr_q <= 1'b0;
    end
  end

  always_comb begin
    cnt_d = clr_q ? 5'h00 : cnt_q;
    shift_d = shift_q;
    regs_d = regs_q;
    wr_tgl_d = wr_tgl_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    frame = {shift_q[afe_spi_pkg::FRAME_BITS-2:0], I_SDI};
    // Clock only clears the counter while select high
    if (!I_CS_N && cnt_d != afe_spi_pkg::CNT_LAST) begin
      // MSB first, one bit per rising edge
      shift_d = frame;
      cnt_d = cnt_d + 5'h01;
      // Commit on the sixteenth rising edge
      if (cnt_d == afe_spi_pkg::CNT_LAST && frame[afe_spi_pkg::RW_POS] == afe_spi_pkg::RW_WRITE) begin
        regs_d[addr_of(frame)] = frame[afe_spi_pkg::DATA_MSB:0];
        wr_addr_d = addr_of(frame);
        wr_data_d = frame[afe_spi_pkg::DATA_MSB:0];
        wr_tgl_d = ~wr_tgl_q;
      end
    end
  end

  always_ff @(posedge I_SCLK) begin
    if (link_rst) begin
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      wr_tgl_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
      for (int i = 0; i < afe_spi_pkg::NUM_REGS; i++) begin
        regs_q[i] <= afe_spi_pkg::REG_RESET;
      end
    end else begin
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      wr_tgl_q <= wr_tgl_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      regs_q <= regs_d;
    end
  end

  // ********************************
  // Transmit side, falling edge
  // ********************************
  logic [afe_spi_pkg::DATA_W-1:0] tx_q;
  logic [afe_spi_pkg::DATA_W-1:0] tx_d;
  logic oe_q;
  logic oe_d;
  logic is_read;
  logic [afe_spi_pkg::FRAME_BITS-1:0] head;

  always_comb begin
    tx_d = tx_q;
    oe_d = oe_q;
    // Nine bits in, aligned to the frame layout
    head = shift_q << (afe_spi_pkg::FRAME_BITS - afe_spi_pkg::CNT_READ_START);
    // Flag bit 0 selects a read
    is_read = (head[afe_spi_pkg::RW_POS] != afe_spi_pkg::RW_WRITE);
    if (I_CS_N || clr_q) begin
      oe_d = 1'b0;
    end else if (cnt_q == afe_spi_pkg::CNT_READ_START && is_read) begin
      // Ninth falling edge drives the first data bit
      tx_d = regs_q[addr_of(head)];
      oe_d = 1'b1;
    end else if (oe_q) begin
      // Next bit on each later falling edge
      tx_d = {tx_q[afe_spi_pkg::DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge I_SCLK) begin
    if (link_rst) begin
      tx_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      oe_q <= oe_d;
    end
  end

  assign O_SDO = tx_q[afe_spi_pkg::DATA_MSB];
  assign O_SDO_OE = oe_q & ~I_CS_N;

  // ********************************
  // Write event into system domain
  // ********************************
  logic tgl_sync;
  logic tgl_prev_q;
  logic tgl_prev_d;
  logic stb_q;
  logic stb_d;
  logic [afe_spi_pkg::ADDR_W-1:0] oaddr_q;
  logic [afe_spi_pkg::ADDR_W-1:0] oaddr_d;
  logic [afe_spi_pkg::DATA_W-1:0] odata_q;
  logic [afe_spi_pkg::DATA_W-1:0] odata_d;

  afe_spi_sync u_tgl_sync (
    .clk(I_REF_CLK),
    .srst(I_SRST),
    .ce(I_CE),
    .i_async(wr_tgl_q),
    .o_sync(tgl_sync)
  );

  always_comb begin
    tgl_prev_d = tgl_prev_q;
    stb_d = stb_q;
    oaddr_d = oaddr_q;
    odata_d = odata_q;
    if (I_CE) begin
      tgl_prev_d = tgl_sync;
      stb_d = tgl_sync ^ tgl_prev_q;
      if (tgl_sync ^ tgl_prev_q) begin
        // Held stable since the toggle; carry out the write
        oaddr_d = wr_addr_q;
        odata_d = wr_data_q;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      tgl_prev_q <= 1'b0;
      stb_q <= 1'b0;
      oaddr_q <= 7'h00;
      odata_q <= 8'h00;
    end else begin
      tgl_prev_q <= tgl_prev_d;
      stb_q <= stb_d;
      oaddr_q <= oaddr_d;
      odata_q <= odata_d;
    end
  end

  assign O_WR_STROBE = stb_q;
  assign O_WR_ADDR = oaddr_q;
  assign O_WR_DATA = odata_q;

  // ********************************
  // Checks
  // ********************************
  a_cnt_bound: assert property (@(posedge I_SCLK) disable iff (link_rst || I_SRST)
    cnt_q <= afe_spi_pkg::CNT_LAST) else $error("bit counter beyond frame");
  a_idle_hold: assert property (@(posedge I_SCLK) disable iff (link_rst || I_SRST)
    I_CS_N |=> $stable(shift_q)) else $error("shift moved with select high");
  a_shift_in: assert property (@(posedge I_SCLK) disable iff (link_rst || I_SRST)
    (!I_CS_N && !clr_q && cnt_q < 5'h10) |=> shift_q[0] == $past(I_SDI)) else $error("input bit not sampled");
  a_write_commit: assert property (@(posedge I_SCLK) disable iff (link_rst || I_SRST)
    (!I_CS_N && !clr_q && cnt_q == 5'h0f && shift_q[14] == 1'b1)
    |=> (regs_q[shift_q[14:8]] == shift_q[7:0] && wr_tgl_q != $past(wr_tgl_q)))
    else $error("write not committed");
  a_no_early: assert property (@(posedge I_SCLK) disable iff (link_rst || I_SRST)
    (cnt_q < 5'h0f) |=> $stable(wr_tgl_q) || $past(clr_q) == 1'b0 && $past(cnt_q) == 5'h0f)
    else $error("write before sixteenth edge");
  a_read_start: assert property (@(negedge I_SCLK) disable iff (link_rst || I_SRST)
    (!I_CS_N && !clr_q && cnt_q == afe_spi_pkg::CNT_READ_START && shift_q[8] == 1'b0) |=> oe_q)
    else $error("read not started at ninth fall");
  a_tx_shift: assert property (@(negedge I_SCLK) disable iff (link_rst || I_SRST)
    (oe_q && !I_CS_N && !clr_q && cnt_q != 5'h09) |=> tx_q == {$past(tx_q[6:0]), 1'b0})
    else $error("output not shifted on fall");
  a_no_write_oe: assert property (@(negedge I_SCLK) disable iff (link_rst || I_SRST)
    (cnt_q == 5'h09 && shift_q[8] == 1'b1 && !oe_q) |=> !oe_q) else $error("driven on write frame");
  a_strobe_pulse: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    (stb_q && I_CE) |=> !stb_q) else $error("strobe longer than a cycle");

  c_write: cover property (@(posedge I_SCLK) wr_tgl_q != $past(wr_tgl_q));
  c_read: cover property (@(negedge I_SCLK) oe_q && !$past(oe_q));
  c_strobe: cover property (@(posedge I_REF_CLK) stb_q);
endmodule

// ==== hw/afe_spi_pkg.sv ====
// Purpose: Shared constants for the front-end serial control port
// Assumes: 16-bit frames, MSB first, read/write flag in bit 15
// Notes: Register storage is 128 entries of 8 bits
package afe_spi_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 128;
  localparam int RW_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 5'h08;
  localparam logic [CNT_W-1:0] CNT_READ_START = 5'h09;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic RW_WRITE = 1'b1;
endpackage

// ==== hw/afe_spi_sync.sv ====
// Purpose: Two-flop level synchroniser
// Assumes: Input is asynchronous to clk
// Notes: First flop is read only by the second
`timescale 1ns/10ps
module afe_spi_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Data
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = ce ? i_async : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule

// ==== testbench/afe_host_model.sv ====
// Purpose: Host serial master model for the front-end control port
// Assumes: Clock idles low and also toggles with select high between frames to clear the counter
// Notes: A released data line reads as the inverse of its last value
`timescale 1ns/10ps
module afe_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic last;
  wire line;
  assign line = sdo_oe ? sdo : ~last;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    last = 1'b0;
  end
  always @(posedge sclk) begin
    if (sdo_oe) begin
      last <= sdo;
    end
  end
  // Clock with select high, clears the bit counter
  task automatic idle(input int n);
    repeat (n) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
  endtask
  // One frame of n bits, MSB first, sampled after each fall
  task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] rx, output logic early,
                      output logic late);
    rx = 8'h00;
    early = 1'b0;
    late = 1'b1;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = tx[15-i];
      #16 sclk = 1'b1;
      #32 sclk = 1'b0;
      #16;
      if (i < 8) begin
        early = early | sdo_oe;
      end else begin
        rx = {rx[6:0], line};
        late = late & sdo_oe;
      end
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    idle(1);
  endtask
endmodule

// ==== testbench/analog_frontend_spi_slave_bench.sv ====
// Purpose: Self-checking bench of the front-end serial control port
// Assumes: Fixed seed, host model on the serial side
// Notes: Expected register content kept in a local array
`timescale 1ns/10ps
module analog_frontend_spi_slave_bench;
  logic I_REF_CLK = 1'b0;
  logic I_SRST = 1'b1;
  logic I_CE = 1'b1;
  logic I_SCLK, I_CS_N, I_SDI, O_SDO, O_SDO_OE, O_WR_STROBE;
  logic [6:0] O_WR_ADDR;
  logic [7:0] O_WR_DATA, rx;
  logic [7:0] mem [128];
  logic early, late;
  int err_count = 0;
  int cmp_count = 0;
  int stb = 0;
  int cyc = 0;
  always #5 I_REF_CLK = ~I_REF_CLK;
  afe_spi_slave dut (.I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST), .I_CE(I_CE), .I_SCLK(I_SCLK),
    .I_CS_N(I_CS_N), .I_SDI(I_SDI), .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE), .O_WR_STROBE(O_WR_STROBE),
    .O_WR_ADDR(O_WR_ADDR), .O_WR_DATA(O_WR_DATA));
  afe_host_model host (.sclk(I_SCLK), .cs_n(I_CS_N), .sdi(I_SDI), .sdo(O_SDO), .sdo_oe(O_SDO_OE));
  always @(posedge I_REF_CLK) begin
    cyc++;
    if (O_WR_STROBE === 1'b1) stb++;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge I_REF_CLK) I_SRST <= 1'b1;
    host.idle(4);
    @(posedge I_REF_CLK) I_SRST <= 1'b0;
    host.idle(2);
    foreach (mem[i]) mem[i] = 8'h00;
  endtask
  task automatic do_write(input logic [6:0] a, input logic [7:0] d, input int n);
    int s;
    s = stb;
    host.xfer({1'b1, a, d}, n, rx, early, late);
    repeat (10) @(posedge I_REF_CLK);
    chk(8'(stb - s), (n == 16) ? 8'h01 : 8'h00);
    if (n == 16) begin
      chk({1'b0, O_WR_ADDR}, {1'b0, a});
      chk(O_WR_DATA, d);
      mem[a] = d;
    end
  endtask
  task automatic do_read(input logic [6:0] a);
    int s;
    s = stb;
    host.xfer({1'b0, a, 8'($urandom)}, 16, rx, early, late);
    chk(rx, mem[a]);
    chk({early, late, O_SDO_OE}, 3'h2);
    chk(8'(stb - s), 8'h00);
  endtask
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    logic [6:0] a;
    void'($urandom(99634));
    fork
      repeat (20) @(posedge I_REF_CLK);
      host.idle(4);
    join
    @(posedge I_REF_CLK) I_SRST <= 1'b0;
    host.idle(2);
    foreach (mem[i]) mem[i] = 8'h00;
    chk(O_WR_DATA, 8'h00);
    do_read(7'h7f);
    do_write(7'h00, 8'hff, 16);
    do_write(7'h7f, 8'ha5, 16);
    do_read(7'h00);
    do_read(7'h7f);
    do_write(7'h00, 8'h3c, 12);
    do_write(7'h7f, 8'h5a, 15);
    do_read(7'h00);
    repeat (24) begin
      a = 7'($urandom);
      do_write(a, 8'($urandom), 16);
      do_read(7'($urandom_range(0, 1) ? a : 7'($urandom)));
    end
    do_reset();
    do_read(7'h7f);
    do_read(a);
    complete_run();
  end
endmodule
